// File: rtl/acr_pkg.sv
// Constants, register map and state codes of the converter control block.
// Overview of operation
// - Result left-justified, low nibble reads zero.
// - Result bytes are read-only to software.
// - Start high then low launches conversion.
// - Start held high resets converter, busy set.
// - Busy flag reads one while converting; resets one.
// - Small variant: 3-bit channel, codes 6,7 amplifiers.
// - Large variant: 4-bit channel, amplifiers, inputs 6-7.
// - Unused control bits read as zero.
// - Setup bit 7 reads one, bits 4-3 zero.
// - Power-off bit zero powers converter; resets zero.
// - Reference select: zero supply, one external; resets zero.
// - Three-bit divider picks converter clock ratio.
// - Pin assign bit moves pin to analog input.
// - Analog pin loses its internal pull-high.
// - Pin assign eight bits large, six small.
// - Conversion end clears busy, raises interrupt request.
package acr_pkg;
    localparam int          ADDR_W         = 5;
    localparam logic [4:0]  OFS_RES_HIGH   = 5'h00;
    localparam logic [4:0]  OFS_RES_LOW    = 5'h04;
    localparam logic [4:0]  OFS_CTRL       = 5'h08;
    localparam logic [4:0]  OFS_SETUP      = 5'h0c;
    localparam logic [4:0]  OFS_PIN        = 5'h10;
    localparam int          CTRL_START_BIT = 7;
    localparam int          CTRL_BUSY_BIT  = 6;
    localparam int          SETUP_ONE_BIT  = 7;
    localparam int          SETUP_PWR_BIT  = 6;
    localparam int          SETUP_REF_BIT  = 5;
    localparam logic [3:0]  CH_RST         = 4'h0;
    localparam logic        BUSY_RST       = 1'b1;
    localparam logic        PWR_RST        = 1'b0;
    localparam logic        REF_RST        = 1'b0;
    localparam logic [2:0]  DIV_RST        = 3'h0;
    localparam logic [7:0]  PIN_RST        = 8'h00;
    localparam logic [3:0]  CH_MASK_SMALL  = 4'h7;
    localparam logic [3:0]  CH_MASK_LARGE  = 4'hf;
    localparam logic [7:0]  PIN_MASK_SMALL = 8'h3f;
    localparam logic [7:0]  PIN_MASK_LARGE = 8'hff;
    localparam logic [3:0]  CH_EXT_LAST    = 4'h5;
    localparam logic [3:0]  CH_AMP1        = 4'h6;
    localparam logic [3:0]  CH_AMP2        = 4'h7;
    localparam logic [3:0]  CH_IN6         = 4'h8;
    localparam logic [3:0]  CH_IN7         = 4'h9;
    localparam logic [2:0]  DIV_BY2        = 3'h0;
    localparam logic [2:0]  DIV_BY8        = 3'h1;
    localparam logic [2:0]  DIV_BY32       = 3'h2;
    localparam logic [2:0]  DIV_BY1        = 3'h4;
    localparam logic [2:0]  DIV_BY4        = 3'h5;
    localparam logic [2:0]  DIV_BY16       = 3'h6;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_CONV = 3'b100
    } acr_state_t;
endpackage

// File: rtl/acr_clk_div.sv
// Converter clock divider producing one tick per converter clock period.
`timescale 1ns/1ps
module acr_clk_div
    import acr_pkg::*;
(
    input  wire logic       ref_clk,  // System clock.
    input  wire logic       rst_n,    // Synchronised reset, active low.
    input  wire logic       enable,   // Run the divider.
    input  wire logic [2:0] div_code, // Divider selection code.
    output logic            tick      // One-cycle converter clock tick.
);
    logic [5:0] ratio;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic       tick_ff;
    logic       nxt_tick;

    always_comb begin
        case (div_code)
            DIV_BY1:  ratio = 6'h01;
            DIV_BY2:  ratio = 6'h02;
            DIV_BY4:  ratio = 6'h04;
            DIV_BY8:  ratio = 6'h08;
            DIV_BY16: ratio = 6'h10;
            DIV_BY32: ratio = 6'h20;
            default:  ratio = 6'h00;
        endcase
    end

    // Undefined codes give no ticks, so the converter stalls rather than runs fast.
    always_comb begin
        nxt_cnt  = cnt_ff;
        nxt_tick = 1'b0;
        if (!enable || ratio == 6'h00) begin
            nxt_cnt = 5'h00;
        end else if ({1'b0, cnt_ff} == ratio - 6'h01) begin
            nxt_cnt  = 5'h00;
            nxt_tick = 1'b1;
        end else begin
            nxt_cnt = cnt_ff + 5'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 5'h00;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick = tick_ff;
endmodule

// File: rtl/acr_top.sv
// Converter control registers with Avalon-MM slave and conversion sequencing.
//
// Local design decisions: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module acr_top
    import acr_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1 // One selects the ten-channel variant.
)
(
    input  wire logic        ref_clk,           // System clock, 20 MHz.
    input  wire logic        rstn,              // Reset, active low, asynchronous.
    input  wire logic [4:0]  avs_address,       // Byte address.
    input  wire logic        avs_read,          // Read request.
    input  wire logic        avs_write,         // Write request.
    input  wire logic [31:0] avs_writedata,     // Write data.
    input  wire logic [3:0]  avs_byteenable,    // Byte enables.
    output logic [31:0]      avs_readdata,      // Read data.
    output logic             avs_waitrequest,   // Stall request.
    input  wire logic        core_done,         // Converter finished, one cycle.
    input  wire logic [11:0] core_data,         // Converter result.
    output logic             core_reset,        // Hold converter in reset.
    output logic             core_start,        // Launch conversion, one cycle.
    output logic             conv_clk_tick,     // Converter clock tick.
    output logic             converter_power_off, // Converter switched off.
    output logic             reference_select,  // Reference source choice.
    output logic [7:0]       analog_inputs_sel, // External input select.
    output logic             amp1_output_sel,   // First amplifier selected.
    output logic             amp2_output_sel,   // Second amplifier selected.
    output logic [7:0]       pin_analog_enable, // Pin taken as analog input.
    output logic [7:0]       pin_digital_off,   // Pin digital role removed.
    output logic [7:0]       pin_pullup_off,    // Pin pull-high disconnected.
    output logic             conv_irq_req       // End of conversion, one cycle.
);
    ////////////////////////////////////////////////////////////////////////////
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [3:0] CH_MASK  = LARGE_VARIANT ? CH_MASK_LARGE : CH_MASK_SMALL;
    localparam logic [7:0] PIN_MASK = LARGE_VARIANT ? PIN_MASK_LARGE : PIN_MASK_SMALL;

    logic        ack_ff;
    logic        nxt_ack;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [7:0]  rd_byte;
    logic        wr_ok;

    logic        start_ff;
    logic        nxt_start;
    logic [3:0]  chan_ff;
    logic [3:0]  nxt_chan;
    logic        pwr_off_ff;
    logic        nxt_pwr_off;
    logic        ref_sel_ff;
    logic        nxt_ref_sel;
    logic [2:0]  div_ff;
    logic [2:0]  nxt_div;
    logic [7:0]  pin_ff;
    logic [7:0]  nxt_pin;

    acr_state_t  state_ff;
    acr_state_t  nxt_state;
    logic        busy_ff;
    logic        nxt_busy;
    logic        launch_ff;
    logic        nxt_launch;
    logic        done_ff;
    logic        nxt_done;
    logic [11:0] result_ff;
    logic [11:0] nxt_result;

    ////////////////////////////////////////////////////////////////////////////
    // One wait state: the request is seen, then answered on the following edge.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
    assign avs_readdata    = rdata_ff;
    assign wr_ok           = avs_write & ack_ff & avs_byteenable[0];

    always_comb begin
        rd_byte = 8'h00;
        if (avs_address == OFS_RES_HIGH) begin
            rd_byte = result_ff[11:4];
        end else if (avs_address == OFS_RES_LOW) begin
            rd_byte = {result_ff[3:0], 4'h0};
        end else if (avs_address == OFS_CTRL) begin
            rd_byte = {start_ff, busy_ff, 2'b00, chan_ff & CH_MASK};
        end else if (avs_address == OFS_SETUP) begin
            rd_byte = {1'b1, pwr_off_ff, ref_sel_ff, 2'b00, div_ff};
        end else if (avs_address == OFS_PIN) begin
            rd_byte = pin_ff & PIN_MASK;
        end
    end

    always_comb begin
        nxt_ack   = (avs_read | avs_write) & ~ack_ff;
        nxt_rdata = rdata_ff;
        if (avs_read & ~ack_ff) begin
            nxt_rdata = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            ack_ff   <= 1'b0;
            rdata_ff <= 32'h00000000;
        end else begin
            ack_ff   <= nxt_ack;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Result offsets have no write path at all.
    always_comb begin
        nxt_start   = start_ff;
        nxt_chan    = chan_ff;
        nxt_pwr_off = pwr_off_ff;
        nxt_ref_sel = ref_sel_ff;
        nxt_div     = div_ff;
        nxt_pin     = pin_ff;
        if (wr_ok) begin
            if (avs_address == OFS_CTRL) begin
                nxt_start = avs_writedata[CTRL_START_BIT];
                nxt_chan  = avs_writedata[3:0] & CH_MASK;
            end else if (avs_address == OFS_SETUP) begin
                nxt_pwr_off = avs_writedata[SETUP_PWR_BIT];
                nxt_ref_sel = avs_writedata[SETUP_REF_BIT];
                nxt_div     = avs_writedata[2:0];
            end else if (avs_address == OFS_PIN) begin
                nxt_pin = avs_writedata[7:0] & PIN_MASK;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            start_ff   <= 1'b0;
            chan_ff    <= CH_RST;
            pwr_off_ff <= PWR_RST;
            ref_sel_ff <= REF_RST;
            div_ff     <= DIV_RST;
            pin_ff     <= PIN_RST;
        end else begin
            start_ff   <= nxt_start;
            chan_ff    <= nxt_chan;
            pwr_off_ff <= nxt_pwr_off;
            ref_sel_ff <= nxt_ref_sel;
            div_ff     <= nxt_div;
            pin_ff     <= nxt_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // A start raised during a conversion aborts it and re-enters the hold state.
    always_comb begin
        nxt_state  = state_ff;
        nxt_busy   = busy_ff;
        nxt_launch = 1'b0;
        nxt_done   = 1'b0;
        nxt_result = result_ff;
        case (state_ff)
            ST_IDLE: begin
                if (start_ff) begin
                    nxt_state = ST_HOLD;
                    nxt_busy  = 1'b1;
                end
            end
            ST_HOLD: begin
                nxt_busy = 1'b1;
                if (!start_ff) begin
                    nxt_state  = ST_CONV;
                    nxt_launch = 1'b1;
                end
            end
            ST_CONV: begin
                if (start_ff) begin
                    nxt_state = ST_HOLD;
                    nxt_busy  = 1'b1;
                end else if (core_done) begin
                    nxt_state  = ST_IDLE;
                    nxt_busy   = 1'b0;
                    nxt_done   = 1'b1;
                    nxt_result = core_data;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            state_ff  <= ST_IDLE;
            busy_ff   <= BUSY_RST;
            launch_ff <= 1'b0;
            done_ff   <= 1'b0;
            result_ff <= 12'h000;
        end else begin
            state_ff  <= nxt_state;
            busy_ff   <= nxt_busy;
            launch_ff <= nxt_launch;
            done_ff   <= nxt_done;
            result_ff <= nxt_result;
        end
    end

    assign core_reset   = (state_ff == ST_HOLD);
    assign core_start   = launch_ff;
    assign conv_irq_req = done_ff;

    acr_clk_div u_clk_div (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n_ff),
        .enable   (~pwr_off_ff & (state_ff == ST_CONV)),
        .div_code (div_ff),
        .tick     (conv_clk_tick)
    );

    ////////////////////////////////////////////////////////////////////////////
    assign converter_power_off = pwr_off_ff;
    assign reference_select    = ref_sel_ff;

    always_comb begin
        analog_inputs_sel = 8'h00;
        amp1_output_sel   = 1'b0;
        amp2_output_sel   = 1'b0;
        if (chan_ff <= CH_EXT_LAST) begin
            analog_inputs_sel[chan_ff[2:0]] = 1'b1;
        end else if (chan_ff == CH_AMP1) begin
            amp1_output_sel = 1'b1;
        end else if (chan_ff == CH_AMP2) begin
            amp2_output_sel = 1'b1;
        end else if (LARGE_VARIANT && chan_ff == CH_IN6) begin
            analog_inputs_sel[6] = 1'b1;
        end else if (LARGE_VARIANT && chan_ff == CH_IN7) begin
            analog_inputs_sel[7] = 1'b1;
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_pin
        assign pin_analog_enable[i] = pin_ff[i] & PIN_MASK[i];
        assign pin_digital_off[i]   = pin_ff[i] & PIN_MASK[i];
        assign pin_pullup_off[i]    = pin_ff[i] & PIN_MASK[i];
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_ff);

    a_low_nibble: assert property (
        (avs_read && !ack_ff && avs_address == OFS_RES_LOW)
        |=> (avs_readdata == {24'h000000, $past(result_ff[3:0]), 4'h0})
    ) else $error("low result byte layout wrong");

    a_result_hold: assert property (
        !(state_ff == ST_CONV && core_done && !start_ff) |=> $stable(result_ff)
    ) else $error("result changed without completion");

    a_launch_fall: assert property (
        (state_ff == ST_HOLD) ##1 (state_ff == ST_HOLD && !start_ff)
        |=> core_start ##1 !core_start
    ) else $error("conversion not launched on start fall");

    a_hold_busy: assert property (
        start_ff |=> (busy_ff && core_reset)
    ) else $error("start high did not reset converter");

    a_done_flags: assert property (
        (state_ff == ST_CONV && core_done && !start_ff)
        |=> (!busy_ff && conv_irq_req && result_ff == $past(core_data))
    ) else $error("completion did not clear busy");

    a_ctrl_unused: assert property (
        (avs_read && !ack_ff && avs_address == OFS_CTRL)
        |=> (avs_readdata[5:4] == 2'b00 && (LARGE_VARIANT || !avs_readdata[3]))
    ) else $error("unused control bits not zero");

    a_setup_fixed: assert property (
        (avs_read && !ack_ff && avs_address == OFS_SETUP)
        |=> (avs_readdata[7] && avs_readdata[4:3] == 2'b00)
    ) else $error("fixed setup bits wrong");

    a_pin_small: assert property (
        !LARGE_VARIANT |-> (pin_analog_enable[7:6] == 2'b00)
    ) else $error("unimplemented pin bits set");

    a_pull_follow: assert property (
        (wr_ok && avs_address == OFS_PIN)
        |=> (pin_pullup_off == ($past(avs_writedata[7:0]) & PIN_MASK)
             && pin_digital_off == pin_pullup_off)
    ) else $error("analog pin kept pull-high");

    a_bus_answer: assert property (
        (avs_read || avs_write) |-> ##[0:1] !avs_waitrequest
    ) else $error("bus answer too late");

    c_full_conv: cover property (
        core_start ##[1:200] conv_irq_req
    );

    c_hold_abort: cover property (
        (state_ff == ST_CONV) ##1 (state_ff == ST_HOLD)
    );

    c_amp_sel: cover property (
        amp2_output_sel && conv_clk_tick
    );
endmodule

// File: verification/acr_core_model.sv
// Behavioural converter core answering launch pulses after a set latency.
`timescale 1ns/1ps
module acr_core_model (
    input  wire logic        ref_clk,    // System clock.
    input  wire logic        rstn,       // Reset, active low.
    input  wire logic        core_reset, // Converter held in reset.
    input  wire logic        core_start, // Launch pulse.
    input  wire logic [8:0]  lat,        // Conversion length in cycles, at least one.
    input  wire logic [11:0] data,       // Value to hand back.
    output logic             core_done,  // Finished pulse.
    output logic [11:0]      core_data   // Result, toggles when not valid.
);
    logic       run;
    logic [8:0] cnt;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            run       <= 1'b0;
            cnt       <= 9'h000;
            core_done <= 1'b0;
            core_data <= 12'h000;
        end else begin
            core_done <= 1'b0;
            core_data <= ~core_data;
            if (core_reset) begin
                run <= 1'b0;
            end else if (core_start) begin
                run <= 1'b1;
                cnt <= lat;
            end else if (run && cnt <= 9'h001) begin
                run       <= 1'b0;
                core_done <= 1'b1;
                core_data <= data;
            end else if (run) begin
                cnt <= cnt - 9'h001;
            end
        end
    end
endmodule

// File: verification/acr_top_bench.sv
// Self-checking bench for the converter control registers.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module acr_top_bench;
    import acr_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic [4:0]  avs_address     = 5'h00;
    logic        avs_read        = 1'b0;
    logic        avs_write       = 1'b0;
    logic [31:0] avs_writedata   = 32'h0;
    logic [3:0]  avs_byteenable  = 4'h1;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        core_done;
    logic [11:0] core_data;
    logic        core_reset;
    logic        core_start;
    logic        conv_clk_tick;
    logic        power_off;
    logic        ref_sel;
    logic [7:0]  in_sel;
    logic        amp1;
    logic        amp2;
    logic [7:0]  pin_an;
    logic [7:0]  pin_dig;
    logic [7:0]  pin_pu;
    logic        irq;
    logic [8:0]  lat   = 9'h005;
    logic [11:0] mdata = 12'h000;
    logic [31:0] exp_q[$];
    logic [31:0] exp_v;
    logic [31:0] s_rdata;
    logic [7:0]  s_in_sel;
    logic [7:0]  s_pin_an;
    logic        s_amp1;
    logic        s_amp2;
    int          bad_count = 0;
    int          tests_run = 0;
    int          start_cnt = 0;
    int          ratio[8] = '{2, 8, 32, 0, 1, 4, 16, 0};

    always #25 ref_clk = ~ref_clk;

    acr_top u_acr_top (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .core_done(core_done), .core_data(core_data),
        .core_reset(core_reset), .core_start(core_start), .conv_clk_tick(conv_clk_tick),
        .converter_power_off(power_off), .reference_select(ref_sel),
        .analog_inputs_sel(in_sel), .amp1_output_sel(amp1), .amp2_output_sel(amp2),
        .pin_analog_enable(pin_an), .pin_digital_off(pin_dig), .pin_pullup_off(pin_pu),
        .conv_irq_req(irq));
    acr_core_model u_acr_core_model (.ref_clk(ref_clk), .rstn(rstn),
        .core_reset(core_reset), .core_start(core_start), .lat(lat), .data(mdata),
        .core_done(core_done), .core_data(core_data));
    // The small variant shares every input, so its answers keep pace with the large one.
    acr_top #(.LARGE_VARIANT(1'b0)) u_acr_top_small (.ref_clk(ref_clk), .rstn(rstn),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(s_rdata), .avs_waitrequest(), .core_done(core_done),
        .core_data(core_data), .core_reset(), .core_start(), .conv_clk_tick(),
        .converter_power_off(), .reference_select(), .analog_inputs_sel(s_in_sel),
        .amp1_output_sel(s_amp1), .amp2_output_sel(s_amp2), .pin_analog_enable(s_pin_an),
        .pin_digital_off(), .pin_pullup_off(), .conv_irq_req());

    ////////////////////////////////////////////////////////////////////////////////
    // The watcher takes the oldest expectation whenever a read completes.
    always @(posedge ref_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            exp_v = exp_q.pop_front();
            `CHK(avs_readdata, exp_v)
        end
        if (core_start === 1'b1) start_cnt++;
    end

    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
        @(posedge ref_clk);
        avs_address    <= a;
        avs_writedata  <= {24'h0, d};
        avs_byteenable <= be;
        avs_write      <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        @(posedge ref_clk);
        avs_address <= a;
        avs_read    <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
    endtask

    // Returns the spacing of two ticks, or zero when none comes.
    task automatic measure(output int iv);
        int n;
        iv = 0;
        for (n = 0; n < 100; n++) begin
            @(posedge ref_clk);
            if (conv_clk_tick === 1'b1) break;
        end
        if (n < 100) begin
            do begin
                @(posedge ref_clk);
                iv++;
            end while (conv_clk_tick !== 1'b1 && iv < 100);
        end
    endtask

    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        bad_count++;
        test_done();
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int          iv;
        int          s0;
        logic [7:0]  r;
        logic [7:0]  e;
        logic [7:0]  es;
        logic [11:0] d;
        void'($urandom(6213));
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rd(OFS_CTRL, 8'h40);
        rd(OFS_SETUP, 8'h80);
        `CHK({power_off, ref_sel}, 2'b00)
        wr(OFS_SETUP, 8'hff);
        rd(OFS_SETUP, 8'he7);
        `CHK({power_off, ref_sel}, 2'b11)
        wr(OFS_SETUP, 8'h00);
        rd(OFS_SETUP, 8'h80);
        for (int i = 0; i < 11; i++) begin
            wr(OFS_CTRL, i[7:0]);
            rd(OFS_CTRL, 8'h40 | i[7:0]);
            e = (i < 6) ? (8'h01 << i) : (i == 8) ? 8'h40 : (i == 9) ? 8'h80 : 8'h00;
            `CHK({in_sel, amp1, amp2}, {e, i == 6, i == 7})
            `CHK(s_rdata, {24'h0, 8'h40 | (i[7:0] & 8'h07)})
            es = (i[2:0] < 3'h6) ? (8'h01 << i[2:0]) : 8'h00;
            `CHK({s_in_sel, s_amp1, s_amp2}, {es, i[2:0] == 3'h6, i[2:0] == 3'h7})
        end
        r = 8'($urandom);
        wr(OFS_PIN, r);
        wr(OFS_PIN, ~r, 4'h0);
        rd(OFS_PIN, r);
        `CHK({pin_an, pin_dig, pin_pu}, {r, r, r})
        `CHK({s_pin_an, s_rdata[7:0]}, {r & 8'h3f, r & 8'h3f})
        wr(5'h14, 8'h5a);
        rd(5'h14, 8'h00);
        wr(OFS_CTRL, 8'hff);
        rd(OFS_CTRL, 8'hcf);
        `CHK(s_rdata, 32'h000000c7)
        lat <= 9'h12c;
        for (int c = 0; c < 8; c++) begin
            wr(OFS_SETUP, c[7:0]);
            wr(OFS_CTRL, 8'h80);
            s0 = start_cnt;
            repeat (5) @(posedge ref_clk);
            `CHK(core_reset, 1'b1)
            rd(OFS_CTRL, 8'hc0);
            `CHK(start_cnt, s0)
            wr(OFS_CTRL, 8'h00);
            rd(OFS_CTRL, 8'h40);
            `CHK(start_cnt, s0 + 1)
            measure(iv);
            `CHK(iv, ratio[c])
        end
        wr(OFS_SETUP, 8'h44);
        measure(iv);
        `CHK(iv, 0)
        wr(OFS_SETUP, 8'h04);
        measure(iv);
        `CHK(iv, 1)
        lat <= 9'h005;
        repeat (3) begin
            d = 12'($urandom);
            mdata <= d;
            wr(OFS_CTRL, 8'h80);
            wr(OFS_CTRL, 8'h00);
            for (iv = 0; iv < 50; iv++) begin
                @(posedge ref_clk);
                if (irq === 1'b1) break;
            end
            `CHK(iv < 50, 1'b1)
            rd(OFS_CTRL, 8'h00);
            rd(OFS_RES_HIGH, d[11:4]);
            rd(OFS_RES_LOW, {d[3:0], 4'h0});
            wr(OFS_RES_HIGH, 8'hff);
            wr(OFS_RES_LOW, 8'hff);
            rd(OFS_RES_HIGH, d[11:4]);
            rd(OFS_RES_LOW, {d[3:0], 4'h0});
        end
        repeat (2) @(posedge ref_clk);
        `CHK(exp_q.size(), 0)
        test_done();
    end
endmodule
